// [core/pcg_defs.svh]
// Constants for the modulator cluster signal glue.
// Assumes inclusion by bare name from core files only.
`ifndef PCG_DEFS_SVH
`define PCG_DEFS_SVH

`define PCG_NUM_MODULES 9
`define PCG_NUM_FINE 8
`define PCG_NUM_DTRIP 15
`define PCG_NUM_GP_DTRIP 12
`define PCG_NUM_TZ 6
`define PCG_NUM_GP_TZ 3
`define PCG_SYNC_STRETCH 8
`define PCG_SOC_STRETCH 32
`define PCG_CNT_W 6
`define PCG_CLK_PERIOD_NS 5

`endif

// [core/pcg_pkg.sv]
// Types shared by the modulator cluster glue.
// Assumes pcg_defs.svh is on the include path.
`include "pcg_defs.svh"

package pcg_pkg;
    typedef logic [`PCG_CNT_W-1:0] pcg_cnt_t;
    typedef logic [`PCG_NUM_MODULES-1:0] pcg_vec_t;
    typedef enum logic [0:0] {
        PCG_IDLE = 1'b0,
        PCG_HOLD = 1'b1
    } pcg_stretch_e;
endpackage : pcg_pkg

// [core/pcg_stretch.sv]
// Pulse stretcher: output high for LEN cycles after the last trigger.
// Assumes trigger is synchronous to clock.
`timescale 1ns/100ps

module pcg_stretch
    import pcg_pkg::*;
#(
    parameter int LEN = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Trigger and stretched output
    input wire logic trig,
    output logic pulse
);
    localparam pcg_cnt_t LEN_M1 = pcg_cnt_t'(LEN - 1);

    pcg_stretch_e state_q;
    pcg_cnt_t cnt_q;

    // Retrigger restarts the count
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= PCG_IDLE;
            cnt_q <= '0;
        end else if (trig) begin
            state_q <= PCG_HOLD;
            cnt_q <= LEN_M1;
        end else begin
            unique case (state_q)
                PCG_IDLE: cnt_q <= '0;
                PCG_HOLD: begin
                    if (cnt_q == '0) begin
                        state_q <= PCG_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
            endcase
        end
    end

    assign pulse = (state_q == PCG_HOLD);

endmodule : pcg_stretch

// [core/pcg_glue.sv]
// Signal glue around a cluster of nine modulator modules.
// Assumes modulators share clock; trip sources and the external sync pin are asynchronous.
`timescale 1ns/100ps
`include "pcg_defs.svh"

module pcg_glue
    import pcg_pkg::*;
#(
    parameter int NUM_MOD = `PCG_NUM_MODULES,
    parameter int SYNC_LEN = `PCG_SYNC_STRETCH,
    parameter int SOC_LEN = `PCG_SOC_STRETCH
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pin mux side
    input wire logic [`PCG_NUM_GP_DTRIP-1:0] mux_trip_lines,
    output logic master_sync_to_mux,
    output logic merged_conv_start_a,
    output logic merged_conv_start_b,
    // Clock control bit
    input wire logic global_timebase_sync_enable,
    // Error sources
    input wire logic ram_double_bit_error,
    input wire logic interrupt_expander_error,
    input wire logic encoder_module_error,
    input wire logic oscillator_failure_flag,
    input wire logic debug_halt,
    // From modulators
    input wire logic master_sync_out,
    input wire logic [NUM_MOD-1:0] conv_start_a,
    input wire logic [NUM_MOD-1:0] conv_start_b,
    input wire logic [NUM_MOD-1:0] modulator_event_irq,
    input wire logic [NUM_MOD-1:0] modulator_trip_irq,
    // To modulators
    output logic external_sync_in,
    output logic [NUM_MOD-1:0] timebase_sync_fanout,
    output logic [`PCG_NUM_DTRIP-1:0] digital_trip_inputs,
    output logic [`PCG_NUM_TZ-1:0] trip_zone_inputs,
    // Fine-edge capability per module
    output logic [NUM_MOD-1:0] fine_edge_modulator,
    // To analog subsystem
    output logic [2*NUM_MOD-1:0] analog_conv_triggers,
    // To interrupt expander
    output logic [NUM_MOD-1:0] event_irq_to_expander,
    output logic [NUM_MOD-1:0] trip_irq_to_expander
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Pin side lines are asynchronous; two flops before any use
    logic [`PCG_NUM_GP_DTRIP-1:0] trip_meta_q;
    logic [`PCG_NUM_GP_DTRIP-1:0] trip_sync_q;
    logic [4:0] err_meta_q;
    logic [4:0] err_sync_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            trip_meta_q <= '0;
            trip_sync_q <= '0;
        end else begin
            trip_meta_q <= mux_trip_lines;
            trip_sync_q <= trip_meta_q;
        end
    end

    // Oscillator flag and errors come from other domains
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            err_meta_q <= '0;
            err_sync_q <= '0;
        end else begin
            err_meta_q <= {debug_halt, oscillator_failure_flag, encoder_module_error,
                           interrupt_expander_error, ram_double_bit_error};
            err_sync_q <= err_meta_q;
        end
    end

    // ----------------------------------------
    // Cluster make-up
    // ----------------------------------------
    // Modules 0..7 fine-edge, last one basic
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fine_edge_modulator <= '0;
        end else begin
            for (int i = 0; i < NUM_MOD; i++) begin
                fine_edge_modulator[i] <= (i < `PCG_NUM_FINE);
            end
        end
    end

    // ----------------------------------------
    // Synchronisation
    // ----------------------------------------
    // Pulse width from source is its own duty; three flops lose nothing
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            external_sync_in <= 1'b0;
        end else begin
            external_sync_in <= trip_sync_q[0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            timebase_sync_fanout <= '0;
        end else begin
            timebase_sync_fanout <= {NUM_MOD{global_timebase_sync_enable}};
        end
    end

    pcg_stretch #(.LEN(SYNC_LEN)) u_sync_stretch (
        .clock(clock),
        .rst_n(rst_n),
        .trig(master_sync_out),
        .pulse(master_sync_to_mux)
    );

    // ----------------------------------------
    // Conversion-start strobes
    // ----------------------------------------
    pcg_stretch #(.LEN(SOC_LEN)) u_conv_start_a_stretch (
        .clock(clock),
        .rst_n(rst_n),
        .trig(|conv_start_a),
        .pulse(merged_conv_start_a)
    );

    pcg_stretch #(.LEN(SOC_LEN)) u_conv_start_b_stretch (
        .clock(clock),
        .rst_n(rst_n),
        .trig(|conv_start_b),
        .pulse(merged_conv_start_b)
    );

    // Unmerged strobes registered once; A in low half
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            analog_conv_triggers <= '0;
        end else begin
            analog_conv_triggers <= {conv_start_b, conv_start_a};
        end
    end

    // ----------------------------------------
    // Trip routing
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            digital_trip_inputs <= '0;
        end else begin
            digital_trip_inputs <= {err_sync_q[1], err_sync_q[0], 1'b0, trip_sync_q};
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            trip_zone_inputs <= '0;
        end else begin
            trip_zone_inputs <= {err_sync_q[4:2], trip_sync_q[`PCG_NUM_GP_TZ-1:0]};
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            event_irq_to_expander <= '0;
            trip_irq_to_expander <= '0;
        end else begin
            event_irq_to_expander <= modulator_event_irq;
            trip_irq_to_expander <= modulator_trip_irq;
        end
    end

    // ----------------------------------------
    // Assertion helpers
    // ----------------------------------------
    // Cycles since last trigger; saturates at 63, so lengths up to 62 only
    function automatic pcg_cnt_t since_step(input pcg_cnt_t cnt, input logic hit);
        if (hit) begin
            return 6'h01;
        end
        return (cnt == '1) ? cnt : cnt + 6'h01;
    endfunction : since_step

    pcg_cnt_t a_since_q;
    pcg_cnt_t b_since_q;
    pcg_cnt_t m_since_q;

    // Counters replace long repetitions in the properties
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            a_since_q <= '1;
            b_since_q <= '1;
            m_since_q <= '1;
        end else begin
            a_since_q <= since_step(a_since_q, |conv_start_a);
            b_since_q <= since_step(b_since_q, |conv_start_b);
            m_since_q <= since_step(m_since_q, master_sync_out);
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_a_strobe;
        |conv_start_a;
    endsequence

    property p_conv_start_a_hold;
        @(posedge clock) disable iff (!rst_n)
        s_a_strobe |=> merged_conv_start_a [*8];
    endproperty
    a_conv_start_a_hold: assert property (p_conv_start_a_hold) else $error("merged A not held");

    property p_conv_start_b_end;
        @(posedge clock) disable iff (!rst_n)
        (b_since_q > SOC_LEN) |-> !merged_conv_start_b;
    endproperty
    a_conv_start_b_end: assert property (p_conv_start_b_end) else $error("merged B too long");

    property p_conv_start_b_start;
        @(posedge clock) disable iff (!rst_n)
        (|conv_start_b) |=> merged_conv_start_b;
    endproperty
    a_conv_start_b_start: assert property (p_conv_start_b_start) else $error("merged B missing");

    property p_sync_len;
        @(posedge clock) disable iff (!rst_n)
        master_sync_out ##1 (!master_sync_out) [*8] |=> !master_sync_to_mux;
    endproperty
    a_sync_len: assert property (p_sync_len) else $error("sync stretch too long");

    property p_sync_hold;
        @(posedge clock) disable iff (!rst_n)
        master_sync_out |=> master_sync_to_mux [*8];
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("sync stretch short");

    property p_restart;
        @(posedge clock) disable iff (!rst_n)
        (merged_conv_start_a && (|conv_start_a)) |=> merged_conv_start_a [*8];
    endproperty
    a_restart: assert property (p_restart) else $error("retrigger lost");

    property p_ext_sync;
        @(posedge clock) disable iff (!rst_n)
        $rose(trip_sync_q[0]) |=> external_sync_in;
    endproperty
    a_ext_sync: assert property (p_ext_sync) else $error("external sync not routed");

    property p_analog;
        @(posedge clock) disable iff (!rst_n)
        1'b1 |=> analog_conv_triggers == {$past(conv_start_b), $past(conv_start_a)};
    endproperty
    a_analog: assert property (p_analog) else $error("analog triggers wrong");

    property p_tz;
        @(posedge clock) disable iff (!rst_n)
        $rose(err_sync_q[4]) |=> trip_zone_inputs[5];
    endproperty
    a_tz: assert property (p_tz) else $error("debug halt not routed");

    property p_irq;
        @(posedge clock) disable iff (!rst_n)
        (|modulator_trip_irq) |=> (|trip_irq_to_expander);
    endproperty
    a_irq: assert property (p_irq) else $error("trip irq lost");

    property p_conv_start_a_level;
        @(posedge clock) disable iff (!rst_n)
        (a_since_q <= SOC_LEN) |-> merged_conv_start_a;
    endproperty
    a_conv_start_a_level: assert property (p_conv_start_a_level) else $error("merged A dropped early");

    property p_conv_start_a_end;
        @(posedge clock) disable iff (!rst_n)
        (a_since_q > SOC_LEN) |-> !merged_conv_start_a;
    endproperty
    a_conv_start_a_end: assert property (p_conv_start_a_end) else $error("merged A too long");

    property p_conv_start_b_level;
        @(posedge clock) disable iff (!rst_n)
        (b_since_q <= SOC_LEN) |-> merged_conv_start_b;
    endproperty
    a_conv_start_b_level: assert property (p_conv_start_b_level) else $error("merged B dropped early");

    property p_sync_level;
        @(posedge clock) disable iff (!rst_n)
        (m_since_q <= SYNC_LEN) |-> master_sync_to_mux;
    endproperty
    a_sync_level: assert property (p_sync_level) else $error("sync stretch dropped early");

    property p_fanout;
        @(posedge clock) disable iff (!rst_n)
        1'b1 |=> timebase_sync_fanout == {NUM_MOD{$past(global_timebase_sync_enable)}};
    endproperty
    a_fanout: assert property (p_fanout) else $error("timebase sync not fanned out");

endmodule : pcg_glue

// [testbench/pcg_far_model.sv]
// Far side model: pin mux trip lines carrying an external sync pulse.
// Assumes requests arrive by nonblocking assignment at the falling edge.
`timescale 1ns/100ps
module pcg_far_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Requests from the bench
    input wire logic [11:0] trip_val,
    input wire logic sync_req,
    // Pin mux lines
    output logic [11:0] mux_trip_lines
);
    logic [1:0] hold_q;
    // Two cycles only: the shortest pulse the modulators must accept
    always_ff @(negedge clock) begin
        if (!rst_n) begin
            hold_q <= 2'h0;
        end else if (sync_req) begin
            hold_q <= 2'h2;
        end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
        end
    end
    assign mux_trip_lines = {trip_val[11:1], trip_val[0] | (hold_q != 2'h0)};
endmodule : pcg_far_model

// [testbench/pcg_glue_tb.sv]
// Bench for the modulator cluster glue, one task per scenario.
// Assumes design outputs settle by the falling edge after each rising edge.
`timescale 1ns/100ps
module pcg_glue_tb
    import pcg_pkg::*;
;
    logic clock = 1'b0, rst_n = 1'b0, tb_en = 1'b0, m_sync = 1'b0, sync_req = 1'b0;
    logic [11:0] trip_val = 12'h000, mux_lines;
    // Order: debug, osc, encoder, expander, ram
    logic [4:0] errs = 5'h00;
    pcg_vec_t soc_a = 9'h000, soc_b = 9'h000, ev_irq = 9'h000, tr_irq = 9'h000;
    pcg_vec_t fan, fine, ev_out, tr_out;
    logic sync_mux, mrg_a, mrg_b, ext_sync;
    logic [14:0] dtrip;
    logic [5:0] tz;
    logic [17:0] analog;
    int n_fail = 0, comparisons = 0;

    initial forever #2.5 clock = ~clock;

    pcg_far_model far (.clock(clock), .rst_n(rst_n), .trip_val(trip_val), .sync_req(sync_req),
        .mux_trip_lines(mux_lines));
    pcg_glue dut (.clock(clock), .rst_n(rst_n), .mux_trip_lines(mux_lines), .master_sync_to_mux(sync_mux),
        .merged_conv_start_a(mrg_a), .merged_conv_start_b(mrg_b), .global_timebase_sync_enable(tb_en),
        .ram_double_bit_error(errs[0]), .interrupt_expander_error(errs[1]), .encoder_module_error(errs[2]),
        .oscillator_failure_flag(errs[3]), .debug_halt(errs[4]), .master_sync_out(m_sync),
        .conv_start_a(soc_a), .conv_start_b(soc_b), .modulator_event_irq(ev_irq),
        .modulator_trip_irq(tr_irq), .external_sync_in(ext_sync), .timebase_sync_fanout(fan),
        .digital_trip_inputs(dtrip), .trip_zone_inputs(tz), .fine_edge_modulator(fine),
        .analog_conv_triggers(analog), .event_irq_to_expander(ev_out), .trip_irq_to_expander(tr_out));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task results;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    // High cycles of all four pulse outputs, so crosstalk shows too
    task expect4(input string what, input int span, input int em, input int ea, input int eb, input int ee);
        int nm, na, nb, ne;
        nm = 0;
        na = 0;
        nb = 0;
        ne = 0;
        for (int k = 0; k < span; k++) begin
            nm += (sync_mux === 1'b1);
            na += (mrg_a === 1'b1);
            nb += (mrg_b === 1'b1);
            ne += (ext_sync === 1'b1);
            @(negedge clock);
        end
        check({what, " sync"}, nm, em);
        check({what, " a"}, na, ea);
        check({what, " b"}, nb, eb);
        check({what, " ext"}, ne, ee);
    endtask : expect4

    task strobe(input pcg_vec_t a, input pcg_vec_t b, input logic m);
        soc_a = a;
        soc_b = b;
        m_sync = m;
        @(negedge clock);
        check("analog", analog, {b, a});
        soc_a = 9'h000;
        soc_b = 9'h000;
        m_sync = 1'b0;
    endtask : strobe

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_static;
        tb_en = 1'b1;
        ev_irq = 9'h155;
        tr_irq = 9'h0aa;
        repeat (2) @(negedge clock);
        check("fanout on", fan, 9'h1ff);
        check("fine", fine, 9'h0ff);
        check("event irq", ev_out, 9'h155);
        check("trip irq", tr_out, 9'h0aa);
        tb_en = 1'b0;
        ev_irq = 9'h000;
        tr_irq = 9'h000;
        repeat (2) @(negedge clock);
        check("fanout off", fan, 9'h000);
        check("event off", ev_out, 9'h000);
        $display("test static done");
    endtask : t_static

    task t_pulses;
        sync_req <= 1'b1;
        @(negedge clock);
        sync_req <= 1'b0;
        expect4("ext", 12, 0, 0, 0, 2);
        strobe(9'h000, 9'h000, 1'b1);
        expect4("master", 16, 8, 0, 0, 0);
        for (int i = 0; i < 9; i++) begin
            strobe(9'h001 << i, 9'h000, 1'b0);
            expect4("soc a", 40, 0, 32, 0, 0);
            strobe(9'h000, 9'h001 << i, 1'b0);
            expect4("soc b", 40, 0, 0, 32, 0);
        end
        strobe(9'h100, 9'h001, 1'b1);
        fork
            expect4("restart", 60, 8, 42, 32, 0);
            begin
                repeat (9) @(negedge clock);
                strobe(9'h010, 9'h000, 1'b0);
            end
        join
        $display("test pulses done");
    endtask : t_pulses

    task t_trip;
        for (int p = 0; p < 2; p++) begin
            trip_val = (p == 1) ? 12'h5a3 : 12'ha5c;
            errs = (p == 1) ? 5'h0a : 5'h15;
            repeat (5) @(negedge clock);
            check("dtrip", dtrip, {errs[1], errs[0], 1'b0, trip_val});
            check("tz", tz, {errs[4:2], trip_val[2:0]});
        end
        $display("test trip done");
    endtask : t_trip

    initial begin
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
        @(negedge clock);
        t_static();
        t_pulses();
        t_trip();
        results();
    end

    // Run needs about 860 cycles; over five times that is ample
    initial begin
        #24000;
        n_fail++;
        results();
    end
endmodule : pcg_glue_tb
